//--- cdn_device_number_capture.sv
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Identity field register: reset value, optional load, otherwise holds

module cdn_field_reg
    import cdn_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VALUE = '0
)
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [W-1:0] loadValue,
    output logic [W-1:0] value
);

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            value <= RESET_VALUE;
        end
        else if (load)
        begin
            value <= loadValue;
        end
        else
        begin
            value <= value;
        end
    end

endmodule : cdn_field_reg

////////////////////////////////////////////////////////////////////////////////
// Device-number capture and the identity part of the status register

module cdn_device_number_capture
    import cdn_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,

    // Address phase of the current bus cycle, already decoded to a strobe
    input wire cdn_addr_phase_s addrPhase,

    // Mirror of the bus number register, which lives elsewhere
    input wire logic [7:0] busNumberIn,

    // Register word and completer identity
    output logic [31:0] statusReg,
    output cdn_completer_id_s completerId
);

    ////////////////////////////////////////////////////////////////////////////
    // Address-phase fields

    wire logic [1:0] adType =
        addrPhase.address[CDN_AD_TYPE_LSB +: 2];
    wire logic [CDN_FUNC_W-1:0] adFunc =
        addrPhase.address[CDN_AD_FUNC_LSB +: CDN_FUNC_W];
    wire logic [CDN_DEV_W-1:0] adDev =
        addrPhase.address[CDN_AD_DEV_LSB +: CDN_DEV_W];

    ////////////////////////////////////////////////////////////////////////////
    // Stored identity fields

    logic [CDN_FUNC_W-1:0] functionNumber;
    logic [CDN_DEV_W-1:0] deviceNumber;
    logic [CDN_BUS_W-1:0] busNumber;

    ////////////////////////////////////////////////////////////////////////////
    // Qualification of a configuration write

    wire logic isCfgWrite =
        addrPhase.command == CDN_CMD_CFG_WRITE;
    wire logic isSelected =
        addrPhase.idselHit;
    wire logic isType0 =
        adType == CDN_AD_TYPE0;
    wire logic funcMatch =
        adFunc == functionNumber;

    // Reads and type 1 cycles fail here, so the field keeps its value
    wire logic captureHit =
        addrPhase.frameStart
        && isCfgWrite
        && isSelected
        && isType0
        && funcMatch;

    // Single-function device: the function number is never reloaded
    wire logic loadFunc = 1'b0;

    // Bus number is mirrored every cycle; writes to it are handled elsewhere
    wire logic loadBus = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Field registers

    cdn_field_reg
    #(
        .W(CDN_FUNC_W),
        .RESET_VALUE(CDN_FUNC_RESET)
    )
    funcField
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .load(loadFunc),
        .loadValue(CDN_FUNC_RESET),
        .value(functionNumber)
    );

    // Loaded whichever internal register the write targets
    // A load reaches the outputs two edges after the address phase
    cdn_field_reg
    #(
        .W(CDN_DEV_W),
        .RESET_VALUE(CDN_DEV_RESET)
    )
    devField
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .load(captureHit),
        .loadValue(adDev),
        .value(deviceNumber)
    );

    cdn_field_reg
    #(
        .W(CDN_BUS_W),
        .RESET_VALUE(CDN_BUS_RESET)
    )
    busField
    (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .load(loadBus),
        .loadValue(busNumberIn),
        .value(busNumber)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Identity word assembly

    function automatic cdn_completer_id_s make_id
    (
        input logic [CDN_BUS_W-1:0] bus,
        input logic [CDN_DEV_W-1:0] dev,
        input logic [CDN_FUNC_W-1:0] func
    );
        cdn_completer_id_s id;
        id.busNumber = bus;
        id.deviceNumber = dev;
        id.functionNumber = func;
        return id;
    endfunction : make_id

    // Upper half belongs to the split-transaction status, outside this block
    wire logic [15:0] upperZero = 16'h0000;

    wire cdn_completer_id_s next_completerId =
        make_id(busNumber, deviceNumber, functionNumber);
    wire cdn_completer_id_s resetCompleterId =
        make_id(CDN_BUS_RESET, CDN_DEV_RESET, CDN_FUNC_RESET);

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs, one cycle behind the fields

    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            statusReg[31:16] <= upperZero;
            statusReg[CDN_BUS_LSB +: CDN_BUS_W] <= CDN_BUS_RESET;
            statusReg[CDN_DEV_LSB +: CDN_DEV_W] <= CDN_DEV_RESET;
            statusReg[CDN_FUNC_LSB +: CDN_FUNC_W] <= CDN_FUNC_RESET;
        end
        else
        begin
            statusReg[31:16] <= upperZero;
            statusReg[CDN_BUS_LSB +: CDN_BUS_W] <= busNumber;
            statusReg[CDN_DEV_LSB +: CDN_DEV_W] <= deviceNumber;
            statusReg[CDN_FUNC_LSB +: CDN_FUNC_W] <= functionNumber;
        end
    end

    // Built from the same fields, so it never disagrees with the status word
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            completerId <= resetCompleterId;
        end
        else
        begin
            completerId <= next_completerId;
        end
    end

endmodule : cdn_device_number_capture

//--- cdn_pkg.sv
package cdn_pkg;

    // Register location and field layout
    localparam logic [7:0] CDN_STATUS_OFFSET = 8'h84;
    localparam int CDN_FUNC_LSB = 0;
    localparam int CDN_FUNC_W = 3;
    localparam int CDN_DEV_LSB = 3;
    localparam int CDN_DEV_W = 5;
    localparam int CDN_BUS_LSB = 8;
    localparam int CDN_BUS_W = 8;

    // Reset values
    localparam logic [2:0] CDN_FUNC_RESET = 3'h0;
    localparam logic [4:0] CDN_DEV_RESET = 5'h1F;
    localparam logic [7:0] CDN_BUS_RESET = 8'hFF;

    // Address-phase fields
    localparam int CDN_AD_TYPE_LSB = 0;
    localparam logic [1:0] CDN_AD_TYPE0 = 2'h0;
    localparam int CDN_AD_FUNC_LSB = 8;
    localparam int CDN_AD_DEV_LSB = 11;

    // Bus command for a configuration write
    localparam logic [3:0] CDN_CMD_CFG_WRITE = 4'hB;

    // Address phase as seen by the capture logic
    typedef struct packed {
        logic frameStart;
        logic [3:0] command;
        logic idselHit;
        logic [31:0] address;
    } cdn_addr_phase_s;

    // Identity sent with split completions
    typedef struct packed {
        logic [7:0] busNumber;
        logic [4:0] deviceNumber;
        logic [2:0] functionNumber;
    } cdn_completer_id_s;

endpackage : cdn_pkg

//--- cdn_checker.sv
`timescale 1ns/1ps
module cdn_checker
    import cdn_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire cdn_addr_phase_s addrPhase,
    input wire logic [7:0] busNumberIn,
    input wire logic [31:0] statusReg,
    input wire cdn_completer_id_s completerId
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    wire logic [31:0] a = addrPhase.address;
    wire logic hit = addrPhase.frameStart && addrPhase.idselHit
        && addrPhase.command == CDN_CMD_CFG_WRITE
        && a[CDN_AD_FUNC_LSB +: 3] == CDN_FUNC_RESET && a[1:0] == CDN_AD_TYPE0;
    chk_dev_load: assert property (hit |-> ##2 statusReg[7:3] == $past(a[15:11], 2))
        else $error("device number not loaded");
    chk_dev_hold: assert property (!hit |-> ##2 $stable(statusReg[7:3]))
        else $error("device number moved");
    chk_cmd_refused: assert property (addrPhase.frameStart
        && addrPhase.command != CDN_CMD_CFG_WRITE |-> ##2 $stable(statusReg[7:3]))
        else $error("non-write command changed device number");
    chk_type1_refused: assert property (addrPhase.frameStart
        && a[1:0] != CDN_AD_TYPE0 |-> ##2 $stable(statusReg[7:3]))
        else $error("type 1 cycle changed device number");
    chk_func_fixed: assert property (statusReg[2:0] == CDN_FUNC_RESET)
        else $error("function number not zero");
    chk_bus_follow: assert property (1'b1 |-> ##2 statusReg[15:8] == $past(busNumberIn, 2))
        else $error("bus number not mirrored");
    chk_id_match: assert property (completerId == statusReg[15:0])
        else $error("completer id differs from status word");
endmodule : cdn_checker
bind cdn_device_number_capture cdn_checker chk(.sys_clk, .rstn, .addrPhase, .busNumberIn,
    .statusReg, .completerId);

//--- cdn_initiator.sv
`timescale 1ns/1ps
module cdn_initiator
    import cdn_pkg::*;
(
    input wire logic sys_clk,
    output cdn_addr_phase_s addrPhase
);
    initial addrPhase = '0;
    task automatic issue(logic [3:0] c, logic s, logic [31:0] a);
        @(negedge sys_clk) addrPhase = '{1'h1, c, s, a};
        // Inverted idle AD, never stale
        @(negedge sys_clk) addrPhase = '{1'h0, c, 1'h0, ~a};
    endtask : issue
endmodule : cdn_initiator

//--- cdn_device_number_capture_tb_top.sv
`timescale 1ns/1ps
module cdn_device_number_capture_tb_top;
    import cdn_pkg::*;
    logic sys_clk = 0, rstn = 0;
    cdn_addr_phase_s addrPhase;
    logic [31:0] statusReg;
    logic [7:0] busNumberIn = 8'h3C;
    cdn_completer_id_s completerId;
    int miscompares = 0, compares = 0;
    always #2.5 sys_clk = ~sys_clk;
    cdn_initiator ini(.sys_clk, .addrPhase);
    cdn_device_number_capture dut(.sys_clk, .rstn, .addrPhase, .busNumberIn,
        .statusReg, .completerId);
    task automatic check(string n, logic [31:0] s, e);
        compares++;
        if (s !== e) $display("unexpected %s %h %h", n, e, s);
        miscompares += (s !== e);
    endtask : check
    task automatic send(logic [3:0] c, logic s, logic [31:0] a, logic [15:0] e);
        ini.issue(c, s, a);
        repeat (2) @(negedge sys_clk);
        check("id", completerId, e);
        check("status", statusReg, {16'h0000, e});
    endtask : send
    task automatic scenario_accept();
        send(4'hB, 1'h1, 32'hC800, 16'h3CC8);
        send(4'hB, 1'h1, 32'h5000, 16'h3C50);
    endtask : scenario_accept
    task automatic scenario_refuse();
        send(4'hA, 1'h1, 32'h2800, 16'h3C50);
        send(4'hB, 1'h0, 32'h2800, 16'h3C50);
        send(4'hB, 1'h1, 32'h2801, 16'h3C50);
        send(4'hB, 1'h1, 32'h2900, 16'h3C50);
    endtask : scenario_refuse
    task automatic scenario_bus();
        @(negedge sys_clk);
        busNumberIn = 8'h5A;
        repeat (3) @(negedge sys_clk);
        check("bus", completerId, 16'h5A50);
    endtask : scenario_bus
    task automatic scenario_reset_again();
        @(negedge sys_clk);
        rstn = 0;
        repeat (2) @(negedge sys_clk);
        check("rst2", statusReg, 32'h0000FFF8);
        rstn = 1;
        repeat (2) @(negedge sys_clk);
        check("id2", completerId, 16'h5AF8);
    endtask : scenario_reset_again
    task automatic report_and_stop();
        $display("%0d compares %0d miscompares", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop
    initial
    begin
        repeat (16) @(negedge sys_clk);
        check("rst", statusReg, 32'h0000FFF8);
        rstn = 1;
        scenario_accept();
        scenario_refuse();
        scenario_bus();
        scenario_reset_again();
        report_and_stop();
    end
endmodule : cdn_device_number_capture_tb_top
